/* rtl/icw_pkg.sv */
// Constants and carrier types for the interrupt and wake controller
package icw_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] IDX_REQ  = 8'hC8;
  localparam logic [7:0] IDX_EN   = 8'hC9;
  localparam logic [7:0] IDX_OSCILLATOR_MODE_REGISTER = 8'hCA;
  localparam logic [7:0] IDX_STACK_POINTER_REGISTER = 8'hDF;
  localparam int unsigned PADDR_W = 10;
  localparam logic [PADDR_W-1:0] ADDR_REQ  = {IDX_REQ, 2'h0};
  localparam logic [PADDR_W-1:0] ADDR_EN   = {IDX_EN, 2'h0};
  localparam logic [PADDR_W-1:0] ADDR_OSCILLATOR_MODE_REGISTER = {IDX_OSCILLATOR_MODE_REGISTER, 2'h0};
  localparam logic [PADDR_W-1:0] ADDR_STACK_POINTER_REGISTER = {IDX_STACK_POINTER_REGISTER, 2'h0};

  // ****************************************************************
  // Source bit positions and reset values
  // ****************************************************************
  localparam int unsigned BIT_EXT = 0;
  localparam int unsigned BIT_CAP = 2;
  localparam int unsigned BIT_SER = 3;
  localparam int unsigned BIT_BAS = 4;
  localparam int unsigned BIT_PWA = 5;
  localparam int unsigned BIT_PWB = 6;
  localparam int unsigned BIT_CMP = 7;
  localparam logic [7:0] SRC_MASK       = 8'hFD;
  localparam logic [7:0] SLEEP_SRC_MASK = 8'h01;
  localparam logic [7:0] REQ_RST        = 8'h00;
  localparam logic [7:0] EN_RST         = 8'h00;

  // ****************************************************************
  // Mode and stack register fields
  // ****************************************************************
  localparam int unsigned OSC_GREEN = 4;
  localparam int unsigned OSC_SLEEP = 3;
  localparam int unsigned OSC_SLOW  = 2;
  localparam int unsigned OSC_STPHX = 1;
  localparam int unsigned GIE_BIT   = 7;
  localparam logic [2:0]  STK_PTR_RST = 3'h7;
  localparam logic [10:0] IRQ_VECTOR  = 11'h008;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned HOSC_KHZ    = 16000;
  localparam int unsigned SETTLE_HOSC = 32;
  localparam int unsigned SETTLE_NS   = SETTLE_HOSC * 1000000 / HOSC_KHZ;
  localparam int unsigned SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_GREEN,
    MODE_SLEEP,
    MODE_SETTLE
  } icw_mode_t;

  typedef struct packed {
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [31:0]        pwdata;
  } icw_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } icw_apb_rsp_t;

  typedef struct packed {
    logic        run;
    logic        slow;
    logic        hosc_run;
    logic        losc_run;
    logic        periph_run;
    logic        irq_take;
    logic [10:0] vector;
  } icw_cpu_t;

  localparam icw_cpu_t CPU_RST = '{run: 1'h1, slow: 1'h0, hosc_run: 1'h1, losc_run: 1'h1,
                                   periph_run: 1'h1, irq_take: 1'h0, vector: 11'h000};

endpackage : icw_pkg

/* rtl/icw_sync.sv */
// Two flip-flop synchroniser for the wake port pins
`timescale 1ns/1ps
module icw_sync #(
  parameter int unsigned W = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } icw_sync_st_t;

  icw_sync_st_t s_q;
  icw_sync_st_t s_d;

  always_comb begin
    s_d.meta   = pin_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.stable;

endmodule : icw_sync

/* rtl/icw_settle.sv */
// Oscillator settle counter; done pulses in the CNT-th cycle of run
`timescale 1ns/1ps
module icw_settle #(
  parameter int unsigned CNT = 80
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic run_i,
  output logic      done_o
);

  localparam int unsigned CW = $clog2(CNT);
  localparam logic [CW-1:0] LAST = CW'(CNT - 2);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } icw_settle_st_t;

  icw_settle_st_t s_q;
  icw_settle_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (!run_i) begin
      s_d.cnt  = '0;
      s_d.done = 1'h0;
    end else begin
      s_d.cnt  = s_q.cnt + CW'(1);
      s_d.done = (s_q.cnt == LAST);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;

endmodule : icw_settle

/* rtl/icw_ctrl.sv */
// Interrupt collection, green and sleep mode control, APB register slave
//
// How it works
// - Green request bit set halts execution; system clock oscillator keeps running.
// - Leaving green mode clears the green request bit in hardware.
// - Green ends on wake port change or enabled basic/capture timer overflow.
// - Green wake resumes the mode held before: normal or slow.
// - Wake-capable timers keep counting on the running clock in green mode.
// - PWM timers run in green but their overflow never wakes.
// - Sleep ends only on wake port change; always resumes in normal mode.
// - Sleep wake waits 32 high-speed oscillator cycles before executing.
// - Green wake resumes at once, with no settle delay.
// - Seven sources: six internal and one external edge input.
// - External request arriving in sleep stays latched until execution resumes.
// - Taking an interrupt clears global enable; return from interrupt sets it.
// - Taking an interrupt pushes a stack level and jumps to vector 8.
// - Enable bit layout: 0 ext, 2 capture, 3 serial, 4 basic, 5-6 PWM, 7 comparator.
// - Request flags share the enable layout; a source event sets its flag, except an internal one in sleep or settle.
// - Flags set on their event regardless of the enable bit.
// - Global enable is bit 7 of the stack pointer register.
// - Sleep request bit set stops all oscillators.
`timescale 1ns/1ps
module icw_ctrl
  import icw_pkg::*;
#(
  parameter int unsigned WAKE_W     = 16,
  parameter int unsigned SETTLE_CNT = SETTLE_CYC
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  input  wire icw_apb_req_t      apb_req_i,
  output icw_apb_rsp_t           apb_rsp_o,
  input  wire logic [7:0]        src_evt_i,
  input  wire logic              basic_timer_wake_en_i,
  input  wire logic              capture_timer_wake_en_i,
  input  wire logic [WAKE_W-1:0] wake_port_i,
  input  wire logic              return_from_interrupt_i,
  output icw_cpu_t               cpu_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    icw_mode_t         mode;
    logic [7:0]        req;
    logic [7:0]        en;
    logic              global_irq_enable;
    logic [2:0]        stk;
    logic              green;
    logic              sleep;
    logic              slow;
    logic              stphx;
    logic [WAKE_W-1:0] prev;
    logic [7:0]        hcnt;
    icw_apb_rsp_t      rsp;
    icw_cpu_t          cpu;
  } icw_ctrl_st_t;

  icw_ctrl_st_t      s_q;
  icw_ctrl_st_t      s_d;
  logic [WAKE_W-1:0] port_sync;
  logic              settle_done;
  logic              setup;
  logic              access;
  logic              wr;
  logic              port_chg;
  logic              wake_grn;
  logic              resting;
  logic [7:0]        evt;
  logic [7:0]        pending;

  // ****************************************************************
  // Wake pins and settle timer
  // ****************************************************************
  icw_sync #(
    .W (WAKE_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (wake_port_i),
    .sync_o    (port_sync)
  );

  icw_settle #(
    .CNT (SETTLE_CNT)
  ) u_settle (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .run_i     (s_q.mode == MODE_SETTLE),
    .done_o    (settle_done)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign setup    = apb_req_i.psel && !apb_req_i.penable;
  assign access   = apb_req_i.psel && apb_req_i.penable && s_q.rsp.pready;
  assign wr       = access && apb_req_i.pwrite && !s_q.rsp.pslverr;
  assign port_chg = (port_sync != s_q.prev);
  assign resting  = (s_q.mode == MODE_SLEEP) || (s_q.mode == MODE_SETTLE);
  assign wake_grn = port_chg
                 || (src_evt_i[BIT_BAS] && basic_timer_wake_en_i)
                 || (src_evt_i[BIT_CAP] && capture_timer_wake_en_i);
  assign evt      = src_evt_i & SRC_MASK & (resting ? SLEEP_SRC_MASK : 8'hFF);
  assign pending  = s_q.en & s_q.req & SRC_MASK;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d              = s_q;
    s_d.rsp.pready   = 1'h0;
    s_d.cpu.irq_take = 1'h0;
    s_d.prev         = port_sync;
    s_d.hcnt         = (s_q.mode == MODE_SETTLE) ? s_q.hcnt + 8'h01 : 8'h00;

    // Register read and unmapped answer, prepared in the setup cycle
    if (setup) begin
      s_d.rsp.pready  = 1'h1;
      s_d.rsp.pslverr = 1'h0;
      unique case (apb_req_i.paddr)
        ADDR_REQ:  s_d.rsp.prdata = {24'h000000, s_q.req & SRC_MASK};
        ADDR_EN:   s_d.rsp.prdata = {24'h000000, s_q.en & SRC_MASK};
        ADDR_OSCILLATOR_MODE_REGISTER: s_d.rsp.prdata = {27'h0000000, s_q.green, s_q.sleep, s_q.slow,
                                     s_q.stphx, 1'h0};
        ADDR_STACK_POINTER_REGISTER: s_d.rsp.prdata = {24'h000000, s_q.global_irq_enable, 4'h0, s_q.stk};
        default: begin
          s_d.rsp.prdata  = 32'h00000000;
          s_d.rsp.pslverr = 1'h1;
        end
      endcase
    end

    // Register writes in the access cycle
    if (wr) begin
      unique case (apb_req_i.paddr)
        ADDR_REQ: s_d.req = apb_req_i.pwdata[7:0] & SRC_MASK;
        ADDR_EN:  s_d.en  = apb_req_i.pwdata[7:0] & SRC_MASK;
        ADDR_OSCILLATOR_MODE_REGISTER: begin
          s_d.slow  = apb_req_i.pwdata[OSC_SLOW];
          s_d.stphx = apb_req_i.pwdata[OSC_STPHX];
          if (apb_req_i.pwdata[OSC_SLEEP]) begin
            s_d.sleep = 1'h1;
            s_d.mode  = MODE_SLEEP;
          end else if (apb_req_i.pwdata[OSC_GREEN]) begin
            s_d.green = 1'h1;
            s_d.mode  = MODE_GREEN;
          end
        end
        ADDR_STACK_POINTER_REGISTER: begin
          s_d.global_irq_enable = apb_req_i.pwdata[GIE_BIT];
          s_d.stk = apb_req_i.pwdata[2:0];
        end
        default: s_d.stk = s_q.stk;
      endcase
    end

    // Source events set flags over a same-cycle software write
    s_d.req = s_d.req | evt;

    // Mode sequencing
    unique case (s_q.mode)
      MODE_RUN: begin
        s_d.mode = s_d.mode;
      end
      MODE_GREEN: begin
        if (wake_grn) begin
          s_d.mode  = MODE_RUN;
          s_d.green = 1'h0;
        end
      end
      MODE_SLEEP: begin
        if (port_chg) begin
          s_d.mode  = MODE_SETTLE;
          s_d.sleep = 1'h0;
          s_d.slow  = 1'h0;
          s_d.stphx = 1'h0;
        end
      end
      MODE_SETTLE: begin
        if (settle_done) begin
          s_d.mode = MODE_RUN;
        end
      end
    endcase

    // Interrupt acceptance
    if (return_from_interrupt_i) begin
      s_d.global_irq_enable = 1'h1;
    end
    if ((s_q.mode == MODE_RUN) && s_q.global_irq_enable && (pending != 8'h00)) begin
      s_d.cpu.irq_take = 1'h1;
      s_d.cpu.vector   = IRQ_VECTOR;
      s_d.global_irq_enable          = 1'h0;
    end

    // Outputs towards the core and clock tree
    s_d.cpu.run        = (s_d.mode == MODE_RUN);
    s_d.cpu.slow       = s_d.slow;
    s_d.cpu.hosc_run   = (s_d.mode != MODE_SLEEP) && !s_d.stphx;
    s_d.cpu.losc_run   = (s_d.mode != MODE_SLEEP);
    s_d.cpu.periph_run = !((s_d.mode == MODE_SLEEP) || (s_d.mode == MODE_SETTLE));
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q     <= '0;
      s_q.req <= REQ_RST;
      s_q.en  <= EN_RST;
      s_q.stk <= STK_PTR_RST;
      s_q.cpu <= CPU_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp_o = s_q.rsp;
  assign cpu_o     = s_q.cpu;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_green_wake;
    (s_q.mode == MODE_GREEN) && wake_grn;
  endsequence

  sequence s_back_to_run;
    (s_q.mode == MODE_RUN) && !s_q.green && cpu_o.run;
  endsequence

  property p_green_halt;
    (s_q.mode == MODE_GREEN) |-> (!cpu_o.run && cpu_o.losc_run && s_q.green);
  endproperty
  a_green_halt: assert property (p_green_halt)
    else $error("green mode still executing or clock stopped");

  property p_green_exit;
    s_green_wake |=> s_back_to_run;
  endproperty
  a_green_exit: assert property (p_green_exit)
    else $error("green wake did not clear request and resume");

  property p_green_hold;
    ((s_q.mode == MODE_GREEN) && !wake_grn) |=> (s_q.mode == MODE_GREEN);
  endproperty
  a_green_hold: assert property (p_green_hold)
    else $error("green mode left without a wake event");

  property p_green_resume;
    (s_q.mode == MODE_GREEN) ##1 (s_q.mode == MODE_RUN) |-> (cpu_o.slow == $past(cpu_o.slow));
  endproperty
  a_green_resume: assert property (p_green_resume)
    else $error("green wake changed the clock mode");

  property p_green_timers;
    (s_q.mode == MODE_GREEN) |-> cpu_o.periph_run;
  endproperty
  a_green_timers: assert property (p_green_timers)
    else $error("timers stopped in green mode");

  property p_pwm_no_wake;
    ((s_q.mode == MODE_GREEN) && !port_chg && !basic_timer_wake_en_i && !capture_timer_wake_en_i
      && (src_evt_i[BIT_PWA] || src_evt_i[BIT_PWB])) |=> (s_q.mode == MODE_GREEN);
  endproperty
  a_pwm_no_wake: assert property (p_pwm_no_wake)
    else $error("PWM overflow woke green mode");

  property p_sleep_exit;
    ((s_q.mode == MODE_SLEEP) && port_chg) |=> ((s_q.mode == MODE_SETTLE) && !cpu_o.slow);
  endproperty
  a_sleep_exit: assert property (p_sleep_exit)
    else $error("sleep wake did not head for normal mode");

  property p_sleep_hold;
    ((s_q.mode == MODE_SLEEP) && !port_chg) |=> (s_q.mode == MODE_SLEEP);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("sleep left without a port change");

  property p_settle_len;
    (s_q.mode == MODE_SETTLE) ##1 (s_q.mode != MODE_SETTLE) |->
      ($past(s_q.hcnt) == 8'(SETTLE_CNT - 1)) && cpu_o.run;
  endproperty
  a_settle_len: assert property (p_settle_len)
    else $error("settle delay has the wrong length");

  property p_settle_norun;
    (s_q.mode == MODE_SETTLE) |-> !cpu_o.run;
  endproperty
  a_settle_norun: assert property (p_settle_norun)
    else $error("executing during oscillator settle");

  property p_ext_latch;
    (resting && s_q.req[BIT_EXT] && !wr) |=> s_q.req[BIT_EXT];
  endproperty
  a_ext_latch: assert property (p_ext_latch)
    else $error("external request lost before execution resumed");

  property p_ext_sleep_set;
    (resting && src_evt_i[BIT_EXT]) |=> s_q.req[BIT_EXT];
  endproperty
  a_ext_sleep_set: assert property (p_ext_sleep_set)
    else $error("external edge in sleep not latched");

  property p_take_gie;
    cpu_o.irq_take |-> (!s_q.global_irq_enable && $past(s_q.global_irq_enable) && (cpu_o.vector == 11'h008));
  endproperty
  a_take_gie: assert property (p_take_gie)
    else $error("vector taken without clearing enable or wrong vector");

  property p_return_from_interrupt_gie;
    (return_from_interrupt_i && !wr
      && !((s_q.mode == MODE_RUN) && s_q.global_irq_enable && (pending != 8'h00))) |=> s_q.global_irq_enable;
  endproperty
  a_return_from_interrupt_gie: assert property (p_return_from_interrupt_gie)
    else $error("return from interrupt did not set global enable");

  property p_take_cause;
    cpu_o.irq_take |-> $past((s_q.mode == MODE_RUN) && s_q.global_irq_enable && (pending != 8'h00));
  endproperty
  a_take_cause: assert property (p_take_cause)
    else $error("vector taken without a qualified request");

  property p_take_due;
    ((s_q.mode == MODE_RUN) && s_q.global_irq_enable && (pending != 8'h00)) |=> cpu_o.irq_take;
  endproperty
  a_take_due: assert property (p_take_due)
    else $error("qualified request not taken");

  property p_flag_set;
    ((src_evt_i & SRC_MASK) != 8'h00) && !resting |=>
      ((s_q.req & $past(src_evt_i & SRC_MASK)) == $past(src_evt_i & SRC_MASK));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("source event did not set its flag");

  property p_sleep_osc;
    (s_q.mode == MODE_SLEEP) |-> (!cpu_o.hosc_run && !cpu_o.losc_run && !cpu_o.run);
  endproperty
  a_sleep_osc: assert property (p_sleep_osc)
    else $error("oscillator running in sleep");

endmodule : icw_ctrl

/* test/icw_core_model.sv */
// Behavioural core and event source model facing the controller
`timescale 1ns/1ps
module icw_core_model
  import icw_pkg::*;
(
  input  wire logic     sys_clk_i,
  input  wire logic     reset_n_i,
  input  wire icw_cpu_t cpu_i,
  output logic [7:0]    src_evt_o,
  output logic          return_from_interrupt_o,
  output logic [3:0]    stack_level_o
);
  int unsigned isr_len = 4;
  int unsigned isr_cnt;
  logic        in_isr;

  // ************************************************
  // Stack push on vector entry, return after isr_len executing cycles
  // ************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stack_level_o           <= 4'h0;
      in_isr                  <= 1'b0;
      isr_cnt                 <= 0;
      return_from_interrupt_o <= 1'b0;
    end else begin
      return_from_interrupt_o <= 1'b0;
      if (cpu_i.irq_take === 1'b1) begin
        stack_level_o <= stack_level_o + 4'h1;
        in_isr        <= 1'b1;
        isr_cnt       <= 0;
      end else if (in_isr && cpu_i.run === 1'b1) begin
        isr_cnt <= isr_cnt + 1;
        if (isr_cnt + 1 >= isr_len) begin
          in_isr                  <= 1'b0;
          return_from_interrupt_o <= 1'b1;
          stack_level_o           <= stack_level_o - 4'h1;
        end
      end
    end
  end

  // ************************************************
  // Source event pulses, one cycle each
  // ************************************************
  initial src_evt_o = 8'h00;

  task automatic pulse(input logic [7:0] mask);
    @(posedge sys_clk_i);
    src_evt_o <= mask;
    @(posedge sys_clk_i);
    src_evt_o <= 8'h00;
  endtask : pulse
endmodule : icw_core_model

/* test/test_interrupt_and_wakeup_control.sv */
// Self-checking bench for the interrupt and wake controller
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end
module test_interrupt_and_wakeup_control;
  import icw_pkg::*;
  localparam int unsigned SETTLE_CNT = 6;
  logic         sys_clk_i;
  logic         reset_n_i;
  icw_apb_req_t apb_req;
  icw_apb_rsp_t apb_rsp;
  logic [7:0]   src_evt;
  logic         bwake;
  logic         cwake;
  logic [15:0]  wake_port;
  logic         return_from_interrupt;
  icw_cpu_t     cpu;
  logic [3:0]   stack_level;
  int           n_mismatch;
  int           checks;
  logic [31:0]  rd;
  logic         err;
  logic         hit;
  int           n;

  icw_ctrl #(
    .WAKE_W     (16),
    .SETTLE_CNT (SETTLE_CNT)
  ) dut (
    .sys_clk_i               (sys_clk_i),
    .reset_n_i               (reset_n_i),
    .apb_req_i               (apb_req),
    .apb_rsp_o               (apb_rsp),
    .src_evt_i               (src_evt),
    .basic_timer_wake_en_i   (bwake),
    .capture_timer_wake_en_i (cwake),
    .wake_port_i             (wake_port),
    .return_from_interrupt_i (return_from_interrupt),
    .cpu_o                   (cpu)
  );

  icw_core_model core (
    .sys_clk_i               (sys_clk_i),
    .reset_n_i               (reset_n_i),
    .cpu_i                   (cpu),
    .src_evt_o               (src_evt),
    .return_from_interrupt_o (return_from_interrupt),
    .stack_level_o           (stack_level)
  );

  // ************************************************
  // Bus and wait helpers
  // ************************************************
  task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic serr);
    int k;
    @(posedge sys_clk_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk_i);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 50);
    if (apb_rsp.pready !== 1'b1) n_mismatch++;
    rdat = apb_rsp.prdata;
    serr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb

  task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(input logic [PADDR_W-1:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0, rd, err);
    `CHK(what, e, rd)
  endtask : rdchk

  task automatic wait_take(input int bound, output logic got);
    got = 1'b0;
    repeat (bound) begin
      @(negedge sys_clk_i);
      if (cpu.irq_take === 1'b1) got = 1'b1;
    end
  endtask : wait_take

  task automatic wait_run(input int bound, output int cnt);
    cnt = 0;
    do begin
      @(negedge sys_clk_i);
      cnt++;
    end while (cpu.run !== 1'b1 && cnt < bound);
  endtask : wait_run

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_reset();
    core.isr_len = 400;
    rdchk(ADDR_REQ, 32'h0, "req reset");
    rdchk(ADDR_EN, 32'h0, "en reset");
    rdchk(ADDR_STACK_POINTER_REGISTER, 32'h07, "stack_pointer_register reset");
    apb(1'b0, 10'h3FC, 32'h0, rd, err);
    `CHK("unmapped err", 1'b1, err)
    wr(ADDR_EN, 32'hFF);
    rdchk(ADDR_EN, 32'hFD, "en layout");
  endtask : t_reset

  task automatic t_flags();
    logic [7:0] e;
    e = 8'h00;
    wr(ADDR_EN, 32'h0);
    for (int i = 0; i < 8; i++) begin
      core.pulse(8'h01 << i);
      e[i] = (i != 1);
      rdchk(ADDR_REQ, {24'h0, e}, "req flags");
    end
    wr(ADDR_REQ, 32'h0);
    rdchk(ADDR_REQ, 32'h0, "req cleared");
  endtask : t_flags

  task automatic t_take();
    wr(ADDR_EN, 32'h10);
    core.pulse(8'h10);
    wait_take(10, hit);
    `CHK("take masked", 1'b0, hit)
    wr(ADDR_STACK_POINTER_REGISTER, 32'h87);
    wait_take(3, hit);
    `CHK("take", 1'b1, hit)
    `CHK("vector", 11'h008, cpu.vector)
    `CHK("stack push", 4'h1, stack_level)
    rdchk(ADDR_STACK_POINTER_REGISTER, 32'h07, "gie cleared");
    rdchk(ADDR_REQ, 32'h10, "flag kept");
    wr(ADDR_REQ, 32'h0);
    repeat (400) @(negedge sys_clk_i);
    rdchk(ADDR_STACK_POINTER_REGISTER, 32'h87, "gie restored");
    `CHK("stack pop", 4'h0, stack_level)
  endtask : t_take

  task automatic t_green();
    wr(ADDR_EN, 32'h0);
    bwake <= 1'b1;
    wr(ADDR_OSCILLATOR_MODE_REGISTER, 32'h14);
    repeat (2) @(negedge sys_clk_i);
    `CHK("green halt", 1'b0, cpu.run)
    `CHK("green hosc", 1'b1, cpu.hosc_run)
    `CHK("green periph", 1'b1, cpu.periph_run)
    core.pulse(8'h60);
    wait_run(4, n);
    `CHK("pwm no wake", 1'b0, cpu.run)
    core.pulse(8'h04);
    wait_run(4, n);
    `CHK("capture off", 1'b0, cpu.run)
    core.pulse(8'h10);
    wait_run(10, n);
    `CHK("timer wake", 1, n)
    `CHK("back to slow", 1'b1, cpu.slow)
    rdchk(ADDR_OSCILLATOR_MODE_REGISTER, 32'h04, "green bit auto clear");
    wr(ADDR_OSCILLATOR_MODE_REGISTER, 32'h00);
    wr(ADDR_OSCILLATOR_MODE_REGISTER, 32'h10);
    @(posedge sys_clk_i);
    wake_port <= 16'h0100;
    wait_run(10, n);
    `CHK("port wake", 1'b1, cpu.run)
    `CHK("back to normal", 1'b0, cpu.slow)
    cwake <= 1'b1;
    wr(ADDR_OSCILLATOR_MODE_REGISTER, 32'h10);
    core.pulse(8'h04);
    wait_run(10, n);
    `CHK("capture wake", 1, n)
    wr(ADDR_REQ, 32'h0);
  endtask : t_green

  task automatic t_sleep();
    int settle;
    wr(ADDR_EN, 32'h01);
    wr(ADDR_OSCILLATOR_MODE_REGISTER, 32'h0E);
    repeat (2) @(negedge sys_clk_i);
    `CHK("sleep run", 1'b0, cpu.run)
    `CHK("sleep osc", 2'b00, {cpu.hosc_run, cpu.losc_run})
    `CHK("sleep periph", 1'b0, cpu.periph_run)
    core.pulse(8'h10);
    core.pulse(8'h01);
    wait_run(4, n);
    `CHK("sleep timer no wake", 1'b0, cpu.run)
    @(posedge sys_clk_i);
    wake_port <= 16'h0001;
    settle = 0;
    for (int k = 0; k < 60 && cpu.run !== 1'b1; k++) begin
      @(negedge sys_clk_i);
      if (cpu.hosc_run === 1'b1 && cpu.run === 1'b0) settle++;
    end
    `CHK("settle cycles", SETTLE_CNT, settle)
    `CHK("sleep to normal", 1'b0, cpu.slow)
    `CHK("sleep wake hosc", 1'b1, cpu.hosc_run)
    wait_take(4, hit);
    `CHK("latched ext take", 1'b1, hit)
    rdchk(ADDR_REQ, 32'h01, "ext latched only");
    rdchk(ADDR_OSCILLATOR_MODE_REGISTER, 32'h00, "sleep bits auto clear");
  endtask : t_sleep

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // ************************************************
  // Clock, sequence and watchdog
  // ************************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    reset_n_i  = 1'b0;
    apb_req    = '0;
    bwake      = 1'b0;
    cwake      = 1'b0;
    wake_port  = 16'h0000;
    n_mismatch = 0;
    checks     = 0;
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_flags();
    t_take();
    t_green();
    t_sleep();
    report_and_stop();
  end

  initial begin
    #500000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : test_interrupt_and_wakeup_control
